// [design/lpmc_ctrl.sv]
// Purpose: Power mode controller: power-down and deep power-down entry and wake-up
// Assumes: APB slave, zero wait states; rst_i is the cold reset
// Notes:   sys_rst_o models the reset that follows a deep power-down wake-up
//
// Contract
// - PM 0x2, deep request, WFI enters power-down
// - Power-down gates core, main, peripheral clocks
// - Power-down removes oscillator, flash, analog power
// - Power-down holds state and pin levels
// - Sleep config decides brown-out and LPOSC power
// - Wake config applied to analog on wake
// - Eight enabled pin interrupts wake power-down
// - Brown-out interrupt or reset wakes when powered
// - Watchdog interrupt or reset wakes when powered
// - Serial, two-wire, SPI events also wake
// - Deep power-down keeps only wake logic, retention
// - Deep power-down tri-states pins except wake
// - Block bit refuses deep power-down entry
// - Block clear, PM 0x3, request, WFI enters
// - Wake pin fall ramps regulator, then resets
// - After wake, registers reset except retention, control
// - Flag reports deep power-down wake, software clears
// - PM encodes sleep 0x0, deep-sleep 0x1
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module lpmc_ctrl
   import lpmc_pkg::*;
#(
   parameter int PIN_IRQS = 8,
   parameter int RAMP     = RAMP_CYC
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // APB slave
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [11:0]         paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic      [31:0]         prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   // Core request
   input  wire logic                wfi_i,
   input  wire logic                deep_sleep_request_bit_i,
   // Wake sources (same clock domain)
   input  wire logic [PIN_IRQS-1:0] pin_irq_i,
   input  wire logic [PIN_IRQS-1:0] nested_irq_controller_en_i,
   input  wire logic                bod_irq_i,
   input  wire logic                bod_rst_i,
   input  wire logic                wdt_irq_i,
   input  wire logic                wdt_rst_i,
   input  wire logic [1:0]          serial_wake_i,
   input  wire logic                i2c_wake_i,
   input  wire logic                spi_wake_i,
   // External pin and regulator
   input  wire logic                wake_pin_n_i,
   input  wire logic                vcore_ok_i,
   // Power and clock controls
   output logic                     core_clk_en_o,
   output logic                     main_clk_en_o,
   output logic                     periph_clk_en_o,
   output logic                     wdt_clk_en_o,
   output logic                     fro_pwr_o,
   output logic                     flash_pwr_o,
   output logic                     bod_pwr_o,
   output logic                     lposc_pwr_o,
   output logic [15:0]              analog_pd_o,
   output logic                     state_hold_o,
   output logic                     regulator_on_o,
   output logic                     pins_hiz_o,
   output logic                     sys_rst_o,
   output logic                     wake_irq_o
);
   import lpmc_pkg::*;

   initial
   begin
      if (PIN_IRQS < 1 || PIN_IRQS > 8)
         $error("PIN_IRQS must lie in 1..8");
      if (RAMP < 1 || RAMP > 4096)
         $error("RAMP must lie in 1..4096");
   end

   typedef enum logic [2:0] {
      ST_ACTIVE, ST_PD, ST_DPD, ST_RAMP, ST_RESET
   } lpmc_state_type;

   lpmc_state_type     state_reg;
   logic [2:0]         pm_reg;
   logic               block_reg;
   logic               dpd_flag_reg;
   logic               sleep_flag_reg;
   logic [31:0]        sleepcfg_reg;
   logic [31:0]        wakecfg_reg;
   logic [7:0]         pinstart_reg;
   logic [5:0]         perstart_reg;
   logic [4:0]         brownout_control_reg_reg;
   logic [2:0]         wdmode_reg;
   logic [31:0]        retain_reg [RETAIN_NUM];
   logic [12:0]        ramp_reg;
   logic               wake_pin_s;
   logic               wake_pin_prev_reg;
   logic               wake_fall;
   logic               wr_en;
   logic               rd_en;
   logic               addr_ok;
   logic               soft_rst;
   logic               bod_kept;
   logic               osc_kept;
   logic               pd_wake;
   logic [31:0]        rdata;
   logic [31:0]        power_control_reg_val;

   lpmc_sync #(.WIDTH(1), .INIT(1'b1)) u_wake_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (wake_pin_n_i),
      .q_o   (wake_pin_s)
   );

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         wake_pin_prev_reg <= 1'b1;
      else
         wake_pin_prev_reg <= wake_pin_s;
   end
   assign wake_fall = wake_pin_prev_reg & ~wake_pin_s;

   assign wr_en    = psel_i & penable_i & pwrite_i;
   assign rd_en    = psel_i & ~penable_i & ~pwrite_i;
   assign addr_ok  = (paddr_i[1:0] == 2'b00) && (paddr_i < RETAIN_OFF + 12'(4 * RETAIN_NUM));
   // Wake reset: everything but retention and power control returns to defaults
   assign soft_rst = (state_reg == ST_RESET);
   assign bod_kept = ~sleepcfg_reg[CFG_BOD_BIT];
   assign osc_kept = ~sleepcfg_reg[CFG_LPOSC_BIT];

   // Wake qualification; reset requests need no start-logic enable
   always_comb
   begin
      pd_wake = |(pin_irq_i & pinstart_reg[PIN_IRQS-1:0] & nested_irq_controller_en_i);
      pd_wake = pd_wake | (bod_kept & bod_irq_i & brownout_control_reg_reg[BOD_IRQSEL_BIT]
                           & perstart_reg[PS_BOD_BIT]);
      pd_wake = pd_wake | (bod_kept & bod_rst_i & brownout_control_reg_reg[BOD_RSTEN_BIT]);
      pd_wake = pd_wake | (osc_kept & wdt_irq_i & wdmode_reg[WD_IRQEN_BIT]
                           & perstart_reg[PS_WDT_BIT]);
      pd_wake = pd_wake | (osc_kept & wdt_rst_i & wdmode_reg[WD_RSTEN_BIT]);
      pd_wake = pd_wake | (serial_wake_i[0] & perstart_reg[PS_SER0_BIT])
                        | (serial_wake_i[1] & perstart_reg[PS_SER1_BIT])
                        | (i2c_wake_i & perstart_reg[PS_I2C_BIT])
                        | (spi_wake_i & perstart_reg[PS_SPI_BIT]);
   end

   // Mode sequencer
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_ACTIVE;
         ramp_reg  <= '0;
      end
      else
      begin
         unique case (state_reg)
            ST_ACTIVE:
            begin
               // Main clock source selection is the software's job here
               if (wfi_i && deep_sleep_request_bit_i && pm_reg == PM_POWER_DOWN)
                  state_reg <= ST_PD;
               else if (wfi_i && deep_sleep_request_bit_i && pm_reg == PM_DEEP_PD
                        && !block_reg)
                  state_reg <= ST_DPD;
            end
            ST_PD:
               if (pd_wake)
                  state_reg <= ST_ACTIVE;
            ST_DPD:
               if (wake_fall)
               begin
                  state_reg <= ST_RAMP;
                  ramp_reg  <= '0;
               end
            ST_RAMP:
            begin
               ramp_reg <= ramp_reg + 13'd1;
               if (vcore_ok_i && ramp_reg >= 13'(RAMP - 1))
                  state_reg <= ST_RESET;
            end
            ST_RESET:
               state_reg <= ST_ACTIVE;
         endcase
      end
   end

   // Power control register: survives the wake reset
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pm_reg         <= PM_SLEEP;
         block_reg      <= 1'b0;
         dpd_flag_reg   <= 1'b0;
         sleep_flag_reg <= 1'b0;
      end
      else
      begin
         if (wr_en && paddr_i == POWER_CONTROL_REG_OFF)
         begin
            pm_reg    <= pwdata_i[PM_LSB +: 3];
            block_reg <= pwdata_i[DPD_BLOCK_BIT];
            if (pwdata_i[DPD_FLAG_BIT])
               dpd_flag_reg <= 1'b0;
            if (pwdata_i[SLEEPFLAG_BIT])
               sleep_flag_reg <= 1'b0;
         end
         // Set wins over a same-cycle clear
         if (state_reg == ST_DPD && wake_fall)
            dpd_flag_reg <= 1'b1;
         if (state_reg == ST_PD && pd_wake)
            sleep_flag_reg <= 1'b1;
      end
   end

   // Configuration registers, returned to defaults by the wake reset
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sleepcfg_reg <= SLEEPCFG_RST;
         wakecfg_reg  <= WAKECFG_RST;
         pinstart_reg <= '0;
         perstart_reg <= '0;
         brownout_control_reg_reg  <= '0;
         wdmode_reg   <= '0;
      end
      else if (soft_rst)
      begin
         sleepcfg_reg <= SLEEPCFG_RST;
         wakecfg_reg  <= WAKECFG_RST;
         pinstart_reg <= '0;
         perstart_reg <= '0;
         brownout_control_reg_reg  <= '0;
         wdmode_reg   <= '0;
      end
      else if (wr_en)
      begin
         unique case (paddr_i)
            SLEEPCFG_OFF: sleepcfg_reg <= {16'h0000, pwdata_i[15:0]};
            WAKECFG_OFF:  wakecfg_reg  <= {16'h0000, pwdata_i[15:0]};
            PINSTART_OFF: pinstart_reg <= pwdata_i[7:0];
            PERSTART_OFF: perstart_reg <= pwdata_i[5:0];
            BROWNOUT_CONTROL_REG_OFF:  brownout_control_reg_reg  <= pwdata_i[4:0];
            WDMODE_OFF:   wdmode_reg   <= pwdata_i[2:0];
            default:      ;
         endcase
      end
   end

   // Retention registers: untouched by deep power-down and its reset
   genvar gi;
   generate
      for (gi = 0; gi < RETAIN_NUM; gi++)
      begin : g_ret
         always_ff @(posedge clk_i or posedge rst_i)
         begin
            if (rst_i)
               retain_reg[gi] <= '0;
            else if (wr_en && paddr_i == RETAIN_OFF + 12'(4 * gi))
               retain_reg[gi] <= pwdata_i;
         end
      end
   endgenerate

   assign power_control_reg_val = {20'h00000, dpd_flag_reg, 2'b00, sleep_flag_reg, 4'h0, block_reg, pm_reg};

   always_comb
   begin
      rdata = SLVERR_DATA;
      if (paddr_i >= RETAIN_OFF && addr_ok)
         rdata = retain_reg[3'((paddr_i - RETAIN_OFF) >> 2)];
      else
         unique case (paddr_i)
            POWER_CONTROL_REG_OFF:     rdata = power_control_reg_val;
            SLEEPCFG_OFF: rdata = sleepcfg_reg;
            WAKECFG_OFF:  rdata = wakecfg_reg;
            PINSTART_OFF: rdata = {24'h000000, pinstart_reg};
            PERSTART_OFF: rdata = {26'h0000000, perstart_reg};
            BROWNOUT_CONTROL_REG_OFF:  rdata = {27'h0000000, brownout_control_reg_reg};
            WDMODE_OFF:   rdata = {29'h00000000, wdmode_reg};
            STATUS_OFF:   rdata = {29'h00000000, state_reg};
            default:      rdata = SLVERR_DATA;
         endcase
   end

   // APB answer: data captured in setup, ready in access
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prdata_o  <= '0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o  <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & ~addr_ok;
         if (rd_en)
            prdata_o <= rdata;
      end
   end

   // Power and clock outputs
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         core_clk_en_o   <= 1'b1;
         main_clk_en_o   <= 1'b1;
         periph_clk_en_o <= 1'b1;
         wdt_clk_en_o    <= 1'b1;
         fro_pwr_o       <= 1'b1;
         flash_pwr_o     <= 1'b1;
         bod_pwr_o       <= 1'b1;
         lposc_pwr_o     <= 1'b1;
         analog_pd_o     <= WAKECFG_RST[15:0];
         state_hold_o    <= 1'b0;
         regulator_on_o  <= 1'b1;
         pins_hiz_o      <= 1'b0;
         sys_rst_o       <= 1'b0;
         wake_irq_o      <= 1'b0;
      end
      else
      begin
         core_clk_en_o   <= (state_reg == ST_ACTIVE);
         main_clk_en_o   <= (state_reg == ST_ACTIVE);
         periph_clk_en_o <= (state_reg == ST_ACTIVE);
         wdt_clk_en_o    <= (state_reg == ST_ACTIVE) || (state_reg == ST_PD && osc_kept);
         fro_pwr_o       <= (state_reg == ST_ACTIVE);
         flash_pwr_o     <= (state_reg == ST_ACTIVE);
         bod_pwr_o       <= (state_reg == ST_ACTIVE) || (state_reg == ST_PD && bod_kept);
         lposc_pwr_o     <= (state_reg == ST_ACTIVE) || (state_reg == ST_PD && osc_kept);
         if (state_reg == ST_ACTIVE && wfi_i && deep_sleep_request_bit_i)
            analog_pd_o <= 16'hFFFF;
         else if (state_reg == ST_PD && pd_wake)
            analog_pd_o <= wakecfg_reg[15:0];
         else if (soft_rst)
            analog_pd_o <= WAKECFG_RST[15:0];
         state_hold_o    <= (state_reg == ST_PD);
         regulator_on_o  <= (state_reg != ST_DPD);
         pins_hiz_o      <= (state_reg == ST_DPD) || (state_reg == ST_RAMP);
         sys_rst_o       <= (state_reg == ST_RAMP && vcore_ok_i
                             && ramp_reg >= 13'(RAMP - 1));
         wake_irq_o      <= (state_reg == ST_PD && pd_wake);
      end
   end

   // Checks
   property p_pd_entry;
      @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_ACTIVE && wfi_i && deep_sleep_request_bit_i && pm_reg == PM_POWER_DOWN)
         |=> state_reg == ST_PD;
   endproperty
   a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

   property p_pd_clocks;
      @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_PD |=> !core_clk_en_o && !main_clk_en_o && !fro_pwr_o && !flash_pwr_o;
   endproperty
   a_pd_clocks: assert property (p_pd_clocks) else $error("clocks or power left on");

   property p_bod_cfg;
      @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_PD |=> bod_pwr_o == $past(bod_kept);
   endproperty
   a_bod_cfg: assert property (p_bod_cfg) else $error("brown-out power wrong");

   property p_block;
      @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_ACTIVE && block_reg) |=> state_reg != ST_DPD;
   endproperty
   a_block: assert property (p_block) else $error("blocked deep power-down entered");

   property p_wake_apply;
      @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_PD && pd_wake) |=> state_reg == ST_ACTIVE && analog_pd_o == $past(wakecfg_reg[15:0]);
   endproperty
   a_wake_apply: assert property (p_wake_apply) else $error("wake config not applied");

   property p_hiz;
      @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_DPD |=> pins_hiz_o && !regulator_on_o;
   endproperty
   a_hiz: assert property (p_hiz) else $error("pins not tri-stated");

   property p_flag_set;
      @(posedge clk_i) disable iff (rst_i)
      $rose(dpd_flag_reg) |-> $past(state_reg) == ST_DPD;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag set without wake");

   property p_reset_seq;
      @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_DPD && wake_fall) |=> state_reg == ST_RAMP ##[1:300] sys_rst_o;
   endproperty
   a_reset_seq: assert property (p_reset_seq) else $error("no reset after wake");

   property p_pin_wake;
      @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_PD && |(pin_irq_i & pinstart_reg[PIN_IRQS-1:0] & nested_irq_controller_en_i)) |=> state_reg == ST_ACTIVE;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin wake missed");

   c_pd_cycle:  cover property (@(posedge clk_i) disable iff (rst_i) state_reg == ST_PD ##1 state_reg == ST_ACTIVE);
   c_dpd_cycle: cover property (@(posedge clk_i) disable iff (rst_i) state_reg == ST_RESET);
   c_blocked:   cover property (@(posedge clk_i) disable iff (rst_i)
                                block_reg && wfi_i && deep_sleep_request_bit_i && pm_reg == PM_DEEP_PD);
endmodule : lpmc_ctrl

// [design/lpmc_pkg.sv]
// Purpose: Shared constants for the low power mode controller
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets and field positions used by the controller and its test bench
package lpmc_pkg;
   localparam logic [11:0] POWER_CONTROL_REG_OFF       = 12'h000;
   localparam logic [11:0] SLEEPCFG_OFF   = 12'h004;
   localparam logic [11:0] WAKECFG_OFF    = 12'h008;
   localparam logic [11:0] PINSTART_OFF   = 12'h00C;
   localparam logic [11:0] PERSTART_OFF   = 12'h010;
   localparam logic [11:0] BROWNOUT_CONTROL_REG_OFF    = 12'h014;
   localparam logic [11:0] WDMODE_OFF     = 12'h018;
   localparam logic [11:0] STATUS_OFF     = 12'h01C;
   localparam logic [11:0] RETAIN_OFF     = 12'h020;
   localparam int          RETAIN_NUM     = 5;

   // Power control register layout
   localparam int          PM_LSB         = 0;
   localparam int          DPD_BLOCK_BIT  = 3;
   localparam int          SLEEPFLAG_BIT  = 8;
   localparam int          DPD_FLAG_BIT   = 11;

   localparam logic [2:0]  PM_SLEEP       = 3'h0;
   localparam logic [2:0]  PM_DEEP_SLEEP  = 3'h1;
   localparam logic [2:0]  PM_POWER_DOWN  = 3'h2;
   localparam logic [2:0]  PM_DEEP_PD     = 3'h3;

   // Sleep/wake power configuration bits (1 = powered down)
   localparam int          CFG_BOD_BIT    = 3;
   localparam int          CFG_LPOSC_BIT  = 6;
   localparam logic [31:0] SLEEPCFG_RST   = 32'h0000_FFFF;
   localparam logic [31:0] WAKECFG_RST    = 32'h0000_EDF0;

   // Peripheral start logic bits
   localparam int          PS_WDT_BIT     = 0;
   localparam int          PS_BOD_BIT     = 1;
   localparam int          PS_SER0_BIT    = 2;
   localparam int          PS_SER1_BIT    = 3;
   localparam int          PS_I2C_BIT     = 4;
   localparam int          PS_SPI_BIT     = 5;

   localparam int          BOD_IRQSEL_BIT = 3;
   localparam int          BOD_RSTEN_BIT  = 4;
   localparam int          WD_RSTEN_BIT   = 1;
   localparam int          WD_IRQEN_BIT   = 2;

   // Regulator ramp time before the power-on reset trips
   localparam int          RAMP_NS        = 100;
   localparam int          CLK_NS         = 25;
   localparam int          RAMP_CYC       = (RAMP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [31:0] SLVERR_DATA    = 32'h0000_0000;
endpackage : lpmc_pkg

// [design/lpmc_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Input asynchronous to clk_i
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module lpmc_sync #(
   parameter int          WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Data
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
      end
      else
      begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         always_ff @(posedge clk_i or posedge rst_i)
         begin
            if (rst_i)
               q_o[g] <= INIT[g];
            else if (s2_reg[g] == s3_reg[g])
               q_o[g] <= s3_reg[g];
         end
      end
   endgenerate
endmodule : lpmc_sync

// [sim/lpmc_core_model.sv]
// Purpose: Core, regulator and wake pin model for the power mode controller
// Assumes: One clock; the wake pin has a pull-up
// Notes:   Tasks are called from the bench
`timescale 1ns/1ps
module lpmc_core_model (
   // Clock and regulator
   input  wire logic clk_i,
   input  wire logic regulator_on_i,
   // Core and pin
   output logic      wfi_o,
   output logic      deep_o,
   output logic      vcore_ok_o,
   output logic      wake_pin_n_o
);
   logic [1:0] ramp_reg;
   initial
   begin
      wfi_o = 1'b0;
      deep_o = 1'b0;
      wake_pin_n_o = 1'b1;
      ramp_reg = 2'h0;
   end
   // Core voltage trails the regulator, never ahead of it
   always @(posedge clk_i) ramp_reg <= {ramp_reg[0], regulator_on_i};
   assign vcore_ok_o = ramp_reg[1];
   // Core code has already moved the main clock to the oscillator
   task sleep_req;
      @(posedge clk_i);
      wfi_o <= 1'b1;
      deep_o <= 1'b1;
      @(posedge clk_i);
      wfi_o <= 1'b0;
      deep_o <= 1'b0;
   endtask : sleep_req
   // Released pin returns to the pull-up level
   task pin_fall;
      @(posedge clk_i);
      wake_pin_n_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      wake_pin_n_o <= 1'b1;
   endtask : pin_fall
endmodule : lpmc_core_model

// [sim/low_power_mode_controller_test.sv]
// Purpose: Self-checking bench for the power mode controller
// Assumes: Zero wait APB slave, one clock domain
// Notes:   Random pin, wake config and retention data
`timescale 1ns/1ps
module low_power_mode_controller_test;
   import lpmc_pkg::*;
   logic clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, err, seen;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, seed = 32'h5576DC4C, w, ret [5];
   logic [7:0] pin_irq = 0, nested_irq_controller_en = 0, src = 0;
   logic [2:0] p;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, wfi, deep, vok, wpin, core_clk_en_o, main_clk_en_o, periph_clk_en_o;
   logic wdt_clk_en_o, fro_pwr_o, flash_pwr_o, bod_pwr_o, lposc_pwr_o, state_hold_o, regulator_on_o;
   logic pins_hiz_o, sys_rst_o;
   logic [15:0] analog_pd_o;
   logic wirq;
   int n_fail = 0, checked = 0, n, n_wirq = 0;
   always #12.5 clk_i = ~clk_i;
   lpmc_ctrl u_lpmc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .wfi_i(wfi), .deep_sleep_request_bit_i(deep), .pin_irq_i(pin_irq),
      .nested_irq_controller_en_i(nested_irq_controller_en), .bod_irq_i(src[1]), .bod_rst_i(src[6]), .wdt_irq_i(src[0]), .wdt_rst_i(src[7]),
      .serial_wake_i(src[3:2]), .i2c_wake_i(src[4]), .spi_wake_i(src[5]), .wake_pin_n_i(wpin),
      .vcore_ok_i(vok), .core_clk_en_o(core_clk_en_o), .main_clk_en_o(main_clk_en_o),
      .periph_clk_en_o(periph_clk_en_o), .wdt_clk_en_o(wdt_clk_en_o), .fro_pwr_o(fro_pwr_o),
      .flash_pwr_o(flash_pwr_o), .bod_pwr_o(bod_pwr_o), .lposc_pwr_o(lposc_pwr_o), .analog_pd_o(analog_pd_o),
      .state_hold_o(state_hold_o), .regulator_on_o(regulator_on_o), .pins_hiz_o(pins_hiz_o),
      .sys_rst_o(sys_rst_o), .wake_irq_o(wirq));
   // Count one-cycle wake pulses
   always @(posedge clk_i) if (wirq === 1'b1) n_wirq++;
   lpmc_core_model u_lpmc_core_model (.clk_i(clk_i), .regulator_on_i(regulator_on_o), .wfi_o(wfi),
      .deep_o(deep), .vcore_ok_o(vok), .wake_pin_n_o(wpin));
   function automatic logic [31:0] xs;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge clk_i);
      penable <= 1'b1;
      n = 0;
      do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 20);
      if (pready_o !== 1'b1) chk(0, 1);
      rd = prdata_o;
      err = pslverr_o;
      {psel, penable} <= 2'b00;
   endtask : apb
   task pd(input logic [31:0] pm);
      apb(1, POWER_CONTROL_REG_OFF, pm);
      u_lpmc_core_model.sleep_req();
      repeat (4) @(posedge clk_i);
   endtask : pd
   task results;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      results();
   end
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({16'h0, analog_pd_o}, {16'h0, WAKECFG_RST[15:0]});
      apb(0, SLEEPCFG_OFF, 0);
      chk(rd, SLEEPCFG_RST);
      apb(0, 12'h034, 0);
      chk({31'h0, err}, 1);
      $display("test reset done");
      // Keep brown-out and slow oscillator up so their wakes count
      apb(1, SLEEPCFG_OFF, 32'h0000_FFB7);
      apb(1, BROWNOUT_CONTROL_REG_OFF, 32'h18);
      apb(1, WDMODE_OFF, 32'h6);
      for (int k = 0; k < 8; k++)
      begin
         apb(1, PERSTART_OFF, 32'h1 << k);
         pd({29'h0, PM_POWER_DOWN});
         chk({bod_pwr_o, lposc_pwr_o, wdt_clk_en_o, state_hold_o}, 4'hF);
         chk({core_clk_en_o, main_clk_en_o, periph_clk_en_o, fro_pwr_o, flash_pwr_o}, 0);
         src <= 8'h1 << k;
         repeat (3) @(posedge clk_i);
         chk({core_clk_en_o, main_clk_en_o, fro_pwr_o, state_hold_o}, 4'hE);
         src <= 8'h0;
      end
      $display("test peripheral wake done");
      apb(1, PERSTART_OFF, 0);
      p = 3'(xs());
      w = xs() & 32'hFFFF;
      apb(1, WAKECFG_OFF, w);
      apb(1, PINSTART_OFF, 32'h1 << p);
      nested_irq_controller_en <= ~(8'h1 << p);
      pd({29'h0, PM_POWER_DOWN});
      pin_irq <= 8'hFF;
      repeat (6) @(posedge clk_i);
      chk({31'h0, main_clk_en_o}, 0);
      nested_irq_controller_en <= 8'hFF;
      repeat (3) @(posedge clk_i);
      chk({31'h0, main_clk_en_o}, 1);
      chk({16'h0, analog_pd_o}, w);
      pin_irq <= 8'h0;
      $display("test pin wake done");
      for (int k = 0; k < 4; k++)
      begin
         apb(1, POWER_CONTROL_REG_OFF, k);
         apb(0, POWER_CONTROL_REG_OFF, 0);
         chk(rd & 32'h7, k);
      end
      $display("test mode field done");
      for (int i = 0; i < 5; i++)
      begin
         ret[i] = xs();
         apb(1, RETAIN_OFF + 12'(4 * i), ret[i]);
      end
      pd(32'hB);
      chk({31'h0, pins_hiz_o}, 0);
      pd(32'h3);
      chk({core_clk_en_o, regulator_on_o, pins_hiz_o}, 3'h1);
      fork
         u_lpmc_core_model.pin_fall();
      join_none
      n = 0;
      while (sys_rst_o !== 1'b1 && n < 100)
      begin
         @(posedge clk_i);
         n++;
      end
      seen = sys_rst_o;
      chk({31'h0, seen}, 1);
      repeat (8) @(posedge clk_i);
      apb(0, POWER_CONTROL_REG_OFF, 0);
      chk(rd & 32'h80F, 32'h803);
      apb(0, SLEEPCFG_OFF, 0);
      chk(rd, SLEEPCFG_RST);
      for (int i = 0; i < 5; i++)
      begin
         apb(0, RETAIN_OFF + 12'(4 * i), 0);
         chk(rd, ret[i]);
      end
      apb(1, POWER_CONTROL_REG_OFF, 32'h800);
      apb(0, POWER_CONTROL_REG_OFF, 0);
      chk(rd & 32'h800, 0);
      chk(n_wirq, 9);
      $display("test deep power-down done");
      results();
   end
endmodule : low_power_mode_controller_test
